// ### pkg/pump_seq_map.svh
// Purpose: offsets, field positions, reset values and timing counts for the pump sequencer
// Assumes: 50 MHz core clock, 32-bit register port, byte addressing
// Notes: pressure, flow or level values are whole units of the sensor scale
`ifndef PUMP_SEQ_MAP_SVH
`define PUMP_SEQ_MAP_SVH

// register offsets (byte addresses)
`define REG_CONFIG 8'h00
`define REG_SETPT01 8'h04
`define REG_SETPT23 8'h08
`define REG_SLEEP 8'h0C
`define REG_PRECHG 8'h10
`define REG_PIPE 8'h14
`define REG_ONTIME 8'h18
`define REG_STATUS 8'h1C
`define REG_IRQ_STAT 8'h20
`define REG_IRQ_EN 8'h24
`define REG_IRQ_CLR 8'h28
`define REG_MEAS 8'h2C

// reset values of the parameter registers
`define RST_SETPT 10'h032
`define RST_SLEEP_OFS 7'h07
`define RST_FORCE 10'h014
`define RST_WAKE 10'h005
`define RST_BOOST 10'h000
`define RST_BOOST_T 6'h03
`define RST_PRE_FREQ 7'h1E
`define RST_PRE_T 15'h0000
`define RST_PRE_P 10'h014
`define RST_PIPE_P 10'h000
`define RST_PIPE_T 14'h0000
`define RST_SENSOR_MAX 10'h096
`define RST_T_OFF 14'h001E
`define RST_T1_ON 10'h00F
`define RST_T2_ON 10'h03C
`define RST_MIN_FREQ 7'h0A

// timing: one second tick and derived counts
`define CLK_HZ 50000000
`define TICK_CYCLES (`CLK_HZ)
`define SLEEP_DELAY_S 6
`define SECS_PER_MIN 60
// adc full scale of the 4-20 mA front end, 4 mA at one fifth
`define ADC_FULL 12'hFFF
`define ADC_ZERO 12'h333
`define ADC_SPAN 12'hCCC

// interrupt bit positions
`define IRQ_SLEEP 0
`define IRQ_WAKE 1
`define IRQ_PIPE 2
`define IRQ_PRE_DONE 3

`endif

// ### pkg/pump_seq_pkg.sv
// Purpose: types shared by the pump sequencer
// Assumes: map header not included; the state numbers are set here
// Notes: state codes written out
package pump_seq_pkg;
  typedef enum logic [2:0] {
    ST_STOPPED = 3'h0,
    ST_PRECHARGE = 3'h1,
    ST_RUN = 3'h2,
    ST_BOOST = 3'h3,
    ST_SLEEP = 3'h4
  } phase_e;
endpackage : pump_seq_pkg

// ### logic/pump_sec_timer.sv
// Purpose: seconds counter that runs while enabled and saturates
// Assumes: tick is a one-cycle pulse once per second
// Notes: clears whenever the enable drops
`timescale 1ns/1ps
module pump_sec_timer (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // control
  input wire logic tick_i,
  input wire logic run_i,
  // elapsed seconds
  output logic [19:0] secs_o
);
  typedef struct packed {
    logic [19:0] secs;
  } tmr_s;
  tmr_s cur, next_cur;

  // count seconds, hold at top so a long wait never wraps
  always_comb begin
    next_cur = cur;
    if (!run_i) begin
      next_cur.secs = 20'h00000;
    end else if (tick_i && cur.secs != 20'hFFFFF) begin
      next_cur.secs = cur.secs + 20'h00001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign secs_o = cur.secs;
endmodule : pump_sec_timer

// ### logic/pump_pressure_sleep_sequencer.sv
// Purpose: constant pressure supervisor: precharge, boost, sleep, wake, broken pipe
// Assumes: run request and adc sample from core logic, register port from cpu
// Notes: regulation loop lives elsewhere; this block sets target and frequency cap
`timescale 1ns/1ps
`include "pump_seq_map.svh"
module pump_pressure_sleep_sequencer (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // measurement and drive state
  input wire logic [11:0] adc_i,
  input wire logic [6:0] out_freq_i,
  input wire logic run_req_i,
  input wire logic pipe_sample_i,
  // control outputs
  output logic motor_on_o,
  output logic [6:0] freq_cap_o,
  output logic [9:0] target_o,
  output logic pipe_fault_o,
  output logic irq_o
);
  typedef struct packed {
    logic cp_mode;
    logic [1:0] sp_sel;
    logic [6:0] min_freq;
    logic [9:0] sensor_max;
    logic [3:0][9:0] setpt;
    logic [6:0] sleep_ofs;
    logic [9:0] force_lvl;
    logic [9:0] wake_lvl;
    logic [9:0] boost_amt;
    logic [5:0] boost_t;
    logic [6:0] pre_freq;
    logic [14:0] pre_t;
    logic [9:0] pre_p;
    logic [9:0] pipe_p;
    logic [13:0] pipe_t;
    logic [13:0] t_off;
    logic [9:0] t1_on;
    logic [9:0] t2_on;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic [31:0] rdata;
    pump_seq_pkg::phase_e phase;
    logic [25:0] tick_cnt;
    logic tick;
    logic [9:0] meas;
    logic long_off;
    logic [5:0] pre_sec;
    logic [14:0] pre_min;
    logic pipe_fault;
  } st_s;
  st_s cur, next_cur;

  logic [19:0] on_secs, off_secs, hold_secs, boost_secs, pipe_secs;
  logic [9:0] sp;
  logic [10:0] sp_force;
  logic [10:0] sp_wake;
  logic [7:0] sleep_freq;
  logic [9:0] min_on;
  logic at_sp, run_phase, hold_ok, pipe_arm, pipe_low;
  logic [21:0] scaled;
  logic [3:0] ev;

  assign sp = cur.setpt[cur.sp_sel];
  assign sp_force = {1'b0, sp} + {1'b0, cur.force_lvl};
  assign sp_wake = {1'b0, sp} - {1'b0, cur.wake_lvl};
  assign sleep_freq = {1'b0, cur.min_freq} + {1'b0, cur.sleep_ofs};
  assign min_on = cur.long_off ? cur.t1_on : cur.t2_on;
  assign at_sp = cur.meas >= sp;
  assign run_phase = cur.phase == pump_seq_pkg::ST_RUN;
  assign hold_ok = run_phase && {1'b0, out_freq_i} <= sleep_freq && at_sp
    && on_secs >= {10'h000, min_on};
  // both zero checks gate the detector
  assign pipe_arm = cur.pipe_p != 10'h000 && cur.pipe_t != 14'h0000 && motor_on_o;
  assign pipe_low = pipe_arm && cur.meas < cur.pipe_p;
  // scale adc span to sensor range
  assign scaled = (adc_i <= `ADC_ZERO) ? 22'h000000
    : 22'(({10'h000, adc_i - `ADC_ZERO} * {12'h000, cur.sensor_max}) / {10'h000, `ADC_SPAN});

  // shared second timers, cleared when not in use
  pump_sec_timer u_on (.core_clk_i(core_clk_i), .reset_i(reset_i), .tick_i(cur.tick),
    .run_i(motor_on_o), .secs_o(on_secs));
  pump_sec_timer u_off (.core_clk_i(core_clk_i), .reset_i(reset_i), .tick_i(cur.tick),
    .run_i(!motor_on_o), .secs_o(off_secs));
  pump_sec_timer u_hold (.core_clk_i(core_clk_i), .reset_i(reset_i), .tick_i(cur.tick),
    .run_i(hold_ok), .secs_o(hold_secs));
  pump_sec_timer u_boost (.core_clk_i(core_clk_i), .reset_i(reset_i), .tick_i(cur.tick),
    .run_i(cur.phase == pump_seq_pkg::ST_BOOST), .secs_o(boost_secs));
  pump_sec_timer u_pipe (.core_clk_i(core_clk_i), .reset_i(reset_i), .tick_i(cur.tick),
    .run_i(pipe_low), .secs_o(pipe_secs));

  // main next-state logic
  always_comb begin
    next_cur = cur;
    ev = 4'h0;
    next_cur.rdata = 32'h00000000;
    next_cur.tick = 1'b0;
    if (cur.tick_cnt == 26'(`TICK_CYCLES - 1)) begin
      next_cur.tick_cnt = 26'h0000000;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.tick_cnt = cur.tick_cnt + 26'h0000001;
    end
    next_cur.meas = (scaled > 22'(cur.sensor_max)) ? cur.sensor_max : scaled[9:0];
    // precharge minute counter, seconds then minutes
    if (cur.phase != pump_seq_pkg::ST_PRECHARGE) begin
      next_cur.pre_sec = 6'h00;
      next_cur.pre_min = 15'h0000;
    end else if (cur.tick) begin
      if (cur.pre_sec == 6'(`SECS_PER_MIN - 1)) begin
        next_cur.pre_sec = 6'h00;
        next_cur.pre_min = cur.pre_min + 15'h0001;
      end else begin
        next_cur.pre_sec = cur.pre_sec + 6'h01;
      end
    end
    unique case (cur.phase)
      pump_seq_pkg::ST_STOPPED: begin
        if (run_req_i && cur.cp_mode) begin
          // remember how long the motor rested
          next_cur.long_off = off_secs > {6'h00, cur.t_off};
          // skip precharge when time is zero
          next_cur.phase = (cur.pre_t == 15'h0000) ? pump_seq_pkg::ST_RUN
            : pump_seq_pkg::ST_PRECHARGE;
        end
      end
      pump_seq_pkg::ST_PRECHARGE: begin
        if (cur.pre_min >= cur.pre_t || cur.meas >= cur.pre_p) begin
          next_cur.phase = pump_seq_pkg::ST_RUN;
          ev[`IRQ_PRE_DONE] = 1'b1;
        end
      end
      pump_seq_pkg::ST_RUN: begin
        if ({1'b0, cur.meas} >= sp_force) begin
          next_cur.phase = pump_seq_pkg::ST_SLEEP;
          ev[`IRQ_SLEEP] = 1'b1;
        end else if (hold_secs >= 20'(`SLEEP_DELAY_S)) begin
          next_cur.phase = pump_seq_pkg::ST_BOOST;
        end
      end
      pump_seq_pkg::ST_BOOST: begin
        // force level, boost target or boost time cap
        if ({1'b0, cur.meas} >= {1'b0, sp} + {1'b0, cur.boost_amt}
            || {1'b0, cur.meas} >= sp_force
            || boost_secs >= {14'h0000, cur.boost_t}) begin
          next_cur.phase = pump_seq_pkg::ST_SLEEP;
          ev[`IRQ_SLEEP] = 1'b1;
        end
      end
      pump_seq_pkg::ST_SLEEP: begin
        // wake once down to setpoint minus threshold
        if (cur.wake_lvl <= sp && {1'b0, cur.meas} <= sp_wake) begin
          next_cur.phase = pump_seq_pkg::ST_RUN;
          next_cur.long_off = off_secs > {6'h00, cur.t_off};
          ev[`IRQ_WAKE] = 1'b1;
        end
      end
      default: next_cur.phase = pump_seq_pkg::ST_STOPPED;
    endcase
    if (!run_req_i || !cur.cp_mode) begin
      next_cur.phase = pump_seq_pkg::ST_STOPPED;
    end
    // fault after broken pipe time in minutes, sticky until mode off or run request drops
    if (pipe_sample_i && pipe_low
        && pipe_secs >= 20'({6'h00, cur.pipe_t} * 20'(`SECS_PER_MIN))) begin
      next_cur.pipe_fault = 1'b1;
      ev[`IRQ_PIPE] = !cur.pipe_fault;
    end
    if (!cur.cp_mode || !run_req_i) begin
      next_cur.pipe_fault = 1'b0;
    end
    // register writes; parameters other than those in the config register only writable in constant pressure mode
    if (wr_i) begin
      unique case (addr_i)
        `REG_CONFIG: begin
          next_cur.cp_mode = wdata_i[0];
          next_cur.sp_sel = wdata_i[2:1];
          next_cur.min_freq = wdata_i[14:8];
          next_cur.sensor_max = wdata_i[25:16];
        end
        `REG_IRQ_EN: next_cur.irq_en = wdata_i[3:0];
        `REG_IRQ_CLR: next_cur.irq_stat = cur.irq_stat & ~wdata_i[3:0];
        default: begin
          if (cur.cp_mode) begin
            unique case (addr_i)
              `REG_SETPT01: {next_cur.setpt[1], next_cur.setpt[0]} =
                {wdata_i[25:16], wdata_i[9:0]};
              `REG_SETPT23: {next_cur.setpt[3], next_cur.setpt[2]} =
                {wdata_i[25:16], wdata_i[9:0]};
              `REG_SLEEP: begin
                next_cur.sleep_ofs = wdata_i[6:0];
                next_cur.force_lvl = wdata_i[17:8];
                next_cur.wake_lvl = wdata_i[27:18];
              end
              `REG_PRECHG: begin
                next_cur.pre_freq = wdata_i[6:0];
                next_cur.pre_t = wdata_i[21:7];
                next_cur.pre_p = wdata_i[31:22];
              end
              `REG_PIPE: begin
                next_cur.pipe_p = wdata_i[9:0];
                next_cur.pipe_t = wdata_i[23:10];
                next_cur.boost_t = wdata_i[29:24];
              end
              `REG_ONTIME: begin
                next_cur.t_off = wdata_i[13:0];
                next_cur.t1_on = wdata_i[23:14];
                next_cur.boost_amt = {2'h0, wdata_i[31:24]};
              end
              default: ;
            endcase
          end
        end
      endcase
    end
    // events set after clear so a same-cycle event wins
    next_cur.irq_stat = next_cur.irq_stat | ev;
    // register reads; parameters other than those in the config register hidden outside constant pressure mode
    if (rd_i) begin
      unique case (addr_i)
        `REG_CONFIG: next_cur.rdata = {6'h00, cur.sensor_max, 1'b0, cur.min_freq,
          5'h00, cur.sp_sel, cur.cp_mode};
        `REG_STATUS: next_cur.rdata = {26'h0000000, cur.pipe_fault, motor_on_o,
          1'b0, cur.phase};
        `REG_IRQ_STAT: next_cur.rdata = {28'h0000000, cur.irq_stat};
        `REG_IRQ_EN: next_cur.rdata = {28'h0000000, cur.irq_en};
        `REG_MEAS: next_cur.rdata = {22'h000000, cur.meas};
        default: begin
          if (cur.cp_mode) begin
            unique case (addr_i)
              `REG_SETPT01: next_cur.rdata = {6'h00, cur.setpt[1], 6'h00, cur.setpt[0]};
              `REG_SETPT23: next_cur.rdata = {6'h00, cur.setpt[3], 6'h00, cur.setpt[2]};
              `REG_SLEEP: next_cur.rdata = {4'h0, cur.wake_lvl, cur.force_lvl, 1'b0,
                cur.sleep_ofs};
              `REG_PRECHG: next_cur.rdata = {cur.pre_p, cur.pre_t, cur.pre_freq};
              `REG_PIPE: next_cur.rdata = {2'h0, cur.boost_t, cur.pipe_t, cur.pipe_p};
              `REG_ONTIME: next_cur.rdata = {cur.boost_amt[7:0], cur.t1_on, cur.t_off};
              default: next_cur.rdata = 32'h00000000;
            endcase
          end
        end
      endcase
    end
  end

  // synchronous reset to stopped with documented defaults
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cur <= '0;
      cur.min_freq <= `RST_MIN_FREQ;
      cur.sensor_max <= `RST_SENSOR_MAX;
      cur.setpt <= {4{`RST_SETPT}};
      cur.sleep_ofs <= `RST_SLEEP_OFS;
      cur.force_lvl <= `RST_FORCE;
      cur.wake_lvl <= `RST_WAKE;
      cur.boost_amt <= `RST_BOOST;
      cur.boost_t <= `RST_BOOST_T;
      cur.pre_freq <= `RST_PRE_FREQ;
      cur.pre_t <= `RST_PRE_T;
      cur.pre_p <= `RST_PRE_P;
      cur.pipe_p <= `RST_PIPE_P;
      cur.pipe_t <= `RST_PIPE_T;
      cur.t_off <= `RST_T_OFF;
      cur.t1_on <= `RST_T1_ON;
      cur.t2_on <= `RST_T2_ON;
      cur.phase <= pump_seq_pkg::ST_STOPPED;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs; cap during precharge, raised target while boosting
  assign motor_on_o = cur.phase == pump_seq_pkg::ST_PRECHARGE || run_phase
    || cur.phase == pump_seq_pkg::ST_BOOST;
  assign freq_cap_o = (cur.phase == pump_seq_pkg::ST_PRECHARGE) ? cur.pre_freq : 7'h7F;
  assign target_o = (cur.phase == pump_seq_pkg::ST_BOOST) ? 10'(sp + cur.boost_amt) : sp;
  assign pipe_fault_o = cur.pipe_fault;
  assign irq_o = |(cur.irq_stat & cur.irq_en);
  assign rdata_o = cur.rdata;
endmodule : pump_pressure_sleep_sequencer

// ### verif/pump_seq_props.sv
// Purpose: port-level checks of the pump pressure sequencer
// Assumes: register writes seen at the port mirror the design's fields
// Notes: shadows only the fields that the checks need
`timescale 1ns/1ps
`include "pump_seq_map.svh"
module pump_seq_props (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // drive side
  input wire logic run_req_i,
  input wire logic motor_on_o,
  input wire logic [6:0] freq_cap_o,
  input wire logic pipe_fault_o,
  input wire logic irq_o
);
  logic cp;
  logic [3:0] en;
  logic pipe_on;
  logic pre_zero;

  // shadow fields; parameter writes only land in constant pressure mode
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cp <= 1'b0;
      en <= 4'h0;
      pipe_on <= 1'b0;
      pre_zero <= 1'b1;
    end else if (wr_i) begin
      if (addr_i == `REG_CONFIG) cp <= wdata_i[0];
      if (addr_i == `REG_IRQ_EN) en <= wdata_i[3:0];
      if (cp && addr_i == `REG_PIPE) pipe_on <= |wdata_i[9:0] && |wdata_i[23:10];
      if (cp && addr_i == `REG_PRECHG) pre_zero <= ~|wdata_i[21:7];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  property p_reset_idle;
    $fell(reset_i) |-> !motor_on_o && freq_cap_o == 7'h7F && !irq_o && !pipe_fault_o;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_cp_hide;
    rd_i && !cp && addr_i >= `REG_SETPT01 && addr_i <= `REG_ONTIME |=> rdata_o == 32'h0;
  endproperty
  a_cp_hide: assert property (p_cp_hide) else $error("hidden register read not zero");
  // read data stands one cycle only
  property p_no_stray;
    !$past(rd_i) |-> rdata_o == 32'h0;
  endproperty
  a_no_stray: assert property (p_no_stray) else $error("read data without read");
  // motor needs a run request
  property p_run_need;
    !run_req_i [*3] |-> !motor_on_o;
  endproperty
  a_run_need: assert property (p_run_need) else $error("motor on without run request");
  property p_cap_idle;
    !motor_on_o |-> freq_cap_o == 7'h7F;
  endproperty
  a_cap_idle: assert property (p_cap_idle) else $error("cap applied with motor off");
  property p_pre_skip;
    pre_zero && $past(pre_zero) |-> freq_cap_o == 7'h7F;
  endproperty
  a_pre_skip: assert property (p_pre_skip) else $error("precharge cap with zero time");
  // masked interrupt stays low
  property p_irq_mask;
    en == 4'h0 && $past(en) == 4'h0 |-> !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while all masked");
  property p_fault_cause;
    $rose(pipe_fault_o) |-> $past(motor_on_o) && pipe_on;
  endproperty
  a_fault_cause: assert property (p_fault_cause) else $error("pipe fault raised");
endmodule : pump_seq_props

bind pump_pressure_sleep_sequencer pump_seq_props u_props (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .run_req_i(run_req_i), .motor_on_o(motor_on_o),
  .freq_cap_o(freq_cap_o), .pipe_fault_o(pipe_fault_o), .irq_o(irq_o));

// ### verif/pump_plant_model.sv
// Purpose: transducer and frequency stage facing the sequencer
// Assumes: bench commands the pressure in raw adc counts
// Notes: speed follows the cap only while the motor may run
`timescale 1ns/1ps
module pump_plant_model (
  // clock
  input wire logic core_clk_i,
  // bench command and sequencer outputs
  input wire logic [11:0] level_i,
  input wire logic motor_on_i,
  input wire logic [6:0] freq_cap_i,
  // to the sequencer
  output logic [11:0] adc_o,
  output logic [6:0] out_freq_o
);
  // a live loop never reads below 4 mA, so clamp to the span
  always_ff @(posedge core_clk_i) begin
    adc_o <= (level_i < 12'h333) ? 12'h333 : level_i;
    out_freq_o <= !motor_on_i ? 7'h00 : (freq_cap_i < 7'h37) ? freq_cap_i : 7'h37;
  end
endmodule : pump_plant_model

// ### verif/pump_pressure_sleep_sequencer_tb.sv
// Purpose: self-checking bench of the pump pressure sequencer
// Assumes: one second tick too long to run, so timed paths are left to the checker
// Notes: levels 0x333, 0x777, 0xFFF scale to 0, 50, 150
`timescale 1ns/1ps
`include "pump_seq_map.svh"
module pump_pressure_sleep_sequencer_tb;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic run_req_i = 1'b0;
  logic [11:0] level = 12'h333;
  logic [31:0] rdata_o;
  logic [11:0] adc_i;
  logic [6:0] out_freq_i;
  logic [6:0] freq_cap_o;
  logic [9:0] target_o;
  logic motor_on_o;
  logic pipe_fault_o;
  logic irq_o;
  logic [31:0] d;
  int mismatches = 0;
  int compares = 0;
  typedef struct packed {logic [7:0] a; logic [31:0] v;} row_s;
  // address beside expected read value, defaults in constant pressure mode
  row_s rows [11] = '{{`REG_CONFIG, 32'h0096_0A01}, {`REG_SETPT01, 32'h0032_0032},
    {`REG_SETPT23, 32'h0032_0032}, {`REG_SLEEP, 32'h0014_1407}, {`REG_PRECHG, 32'h0500_001E},
    {`REG_PIPE, 32'h0300_0000}, {`REG_ONTIME, 32'h0003_C01E}, {`REG_MEAS, 32'h0000_0032},
    {`REG_STATUS, 32'h0}, {`REG_IRQ_CLR, 32'h0}, {8'h30, 32'h0}};

  pump_pressure_sleep_sequencer dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .adc_i(adc_i), .out_freq_i(out_freq_i), .run_req_i(run_req_i), .pipe_sample_i(1'b1),
    .motor_on_o(motor_on_o), .freq_cap_o(freq_cap_o), .target_o(target_o),
    .pipe_fault_o(pipe_fault_o), .irq_o(irq_o));
  pump_plant_model plant (.core_clk_i(core_clk_i), .level_i(level), .motor_on_i(motor_on_o),
    .freq_cap_i(freq_cap_o), .adc_o(adc_i), .out_freq_o(out_freq_i));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe; taken at its closing edge
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(posedge core_clk_i);
    d = rdata_o;
  endtask : rd
  // poll the phase field, bounded, then compare it
  task automatic phase_is(input logic [2:0] p);
    for (int i = 0; i < 40; i++) begin
      rd(`REG_STATUS);
      if (d[2:0] === p) break;
    end
    chk(32'(d[2:0]), 32'(p));
  endtask : phase_is
  task automatic conclude;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // free-running core clock
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  // power-on reset
  initial begin
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
  end
  // hang guard, far beyond the under two hundred cycles needed
  initial begin
    repeat (20000) @(posedge core_clk_i);
    mismatches++;
    conclude();
  end

  initial begin
    wait (reset_i === 1'b0);
    #1;
    chk(32'(motor_on_o), 32'h0);
    rd(`REG_CONFIG);
    chk(d, 32'h0096_0A00);
    rd(`REG_SETPT01);
    chk(d, 32'h0);
    wr(`REG_SETPT01, 32'h00AA_00AA);
    wr(`REG_CONFIG, 32'h0096_0A01);
    level <= 12'h777;
    for (int i = 0; i < 11; i++) begin
      rd(rows[i].a);
      chk(d, rows[i].v);
    end
    wr(`REG_SETPT01, 32'h0029_0028);
    wr(`REG_SETPT23, 32'h002B_002A);
    for (int s = 0; s < 4; s++) begin
      wr(`REG_CONFIG, 32'h0096_0A01 | 32'(s << 1));
      rd(`REG_STATUS);
      chk(32'(target_o), 32'h28 + 32'(s));
    end
    wr(`REG_SETPT01, 32'h0029_0032);
    wr(`REG_CONFIG, 32'h0096_0A01);
    wr(`REG_IRQ_EN, 32'hF);
    run_req_i <= 1'b1;
    phase_is(pump_seq_pkg::ST_RUN);
    chk(32'({freq_cap_o, target_o}), 32'({7'h7F, 10'h032}));
    level <= 12'hFFF;
    phase_is(pump_seq_pkg::ST_SLEEP);
    chk(32'(motor_on_o), 32'h0);
    // 46 sits one unit above the wake level, let it settle
    level <= 12'h720;
    repeat (4) @(posedge core_clk_i);
    rd(`REG_STATUS);
    chk(32'(d[2:0]), 32'(pump_seq_pkg::ST_SLEEP));
    // 45 is exactly setpoint minus wake threshold
    level <= 12'h70A;
    phase_is(pump_seq_pkg::ST_RUN);
    rd(`REG_MEAS);
    chk(d, 32'h0000_002D);
    // zero pipe time keeps the detector off below the threshold
    wr(`REG_PIPE, 32'h0300_0064);
    rd(`REG_STATUS);
    chk(32'({d[5], pipe_fault_o}), 32'h0);
    rd(`REG_IRQ_STAT);
    chk(32'({d[1:0], 1'b0, irq_o}), 32'hD);
    wr(`REG_IRQ_EN, 32'h0);
    rd(`REG_IRQ_STAT);
    chk(32'(irq_o), 32'h0);
    wr(`REG_IRQ_CLR, 32'hF);
    wr(`REG_IRQ_EN, 32'hF);
    rd(`REG_IRQ_STAT);
    chk(d, 32'h0);
    chk(32'(irq_o), 32'h0);
    run_req_i <= 1'b0;
    level <= 12'h333;
    phase_is(pump_seq_pkg::ST_STOPPED);
    // precharge level kept below the first setpoint
    wr(`REG_PRECHG, 32'h0500_00A0);
    run_req_i <= 1'b1;
    phase_is(pump_seq_pkg::ST_PRECHARGE);
    chk(32'(freq_cap_o), 32'h20);
    level <= 12'h777;
    phase_is(pump_seq_pkg::ST_RUN);
    rd(`REG_IRQ_STAT);
    chk(32'(d[3]), 32'h1);
    // second reset in mid-run
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(`REG_CONFIG);
    chk(d, 32'h0096_0A00);
    chk(32'(motor_on_o), 32'h0);
    conclude();
  end
endmodule : pump_pressure_sleep_sequencer_tb
